//--- src/fpl_pkg.sv
// Package of constants and types for the front-panel lock control block.
package fpl_pkg;

    // ****************************************************************
    // Bus map
    // ****************************************************************
    localparam logic [7:0] FPL_ADDR_CTRL    = 8'h00;
    localparam logic [7:0] FPL_ADDR_STATUS  = 8'h04;
    localparam logic [7:0] FPL_ADDR_VALUE   = 8'h08;
    localparam logic [7:0] FPL_ADDR_CAL_LO  = 8'h0C;
    localparam logic [7:0] FPL_ADDR_CAL_HI  = 8'h10;
    localparam logic [7:0] FPL_ADDR_SCALED  = 8'h14;
    localparam logic [7:0] FPL_ADDR_ACTIONS = 8'h18;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int FPL_CTRL_PINFN_LSB = 0;
    localparam int FPL_CTRL_TREND1    = 3;
    localparam int FPL_CTRL_TREND2    = 4;
    localparam int FPL_CTRL_DISP2_LSB = 8;
    localparam int FPL_CTRL_DISP3_LSB = 12;
    localparam int FPL_CTRL_INVALID   = 16;
    localparam logic [31:0] FPL_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] FPL_CTRL_MASK  = 32'h0001_FF1F;

    // ****************************************************************
    // Numeric limits
    // ****************************************************************
    localparam logic signed [31:0] FPL_CAL_MIN_SPAN = 32'sd1000;
    localparam logic signed [31:0] FPL_DISP_MIN     = -32'sd19999;
    localparam logic signed [31:0] FPL_DISP_MAX     = 32'sd99999;
    localparam logic [2:0]  FPL_PINFN_LOCK  = 3'h0;
    localparam logic [2:0]  FPL_PINFN_TARE  = 3'h5;
    localparam logic [2:0]  FPL_PINFN_TOT1  = 3'h6;
    localparam logic [2:0]  FPL_PINFN_UNLAT = 3'h7;
    localparam int FPL_STEP_LAST    = 15;
    localparam int FPL_VIEW_ITEMS   = 7;
    localparam logic [15:0] FPL_VALUE_RESET = 16'h0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int FPL_CLK_MHZ       = 100;
    localparam int FPL_DEBOUNCE_US   = 20;
    localparam int FPL_DEBOUNCE_CYC  = FPL_DEBOUNCE_US * FPL_CLK_MHZ;
    localparam int FPL_DB_W          = 12;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        FPL_OPER, FPL_VIEW_UP, FPL_VIEW_DN, FPL_MAIN, FPL_SETP,
        FPL_EXIT_ARM, FPL_LOCKMSG
    } fpl_mode_t;

endpackage

//--- src/fpl_front_panel_lock.sv
// Front-panel button sequencing, lockout and lock-pin action logic with AXI4-Lite access.
//
// Functional notes
// - In programming, program press commits the shown value and advances a step; here it arms the exit and the next lone press advances the step.
// - Passing steps with program only leaves stored values untouched.
// - Program plus up together enters main programming mode.
// - Program plus down together enters setpoint programming mode.
// - Exit: one program press, then program plus arrow, back to operation.
// - Up press increments the edited value while programming.
// - Down press decrements the edited value while programming.
// - Up in operation walks odd channels, odd setpoints, peak, total one.
// - Down in operation walks even channels, even setpoints, valley, total two.
// - Program lockout on makes everything view only and shows lock notice.
// - Setpoint lockout on refuses setpoint edits but allows viewing.
// - Calibration error when high reading is under low plus 1000 counts.
// - Error when scaled result leaves -19999..99999 or input is invalid.
// - Pin function zero with pin active locks both programming modes.
// - Pin lock still allows brightness; next program press shows lock notice.
// - Pin functions 1..7 reset channels, tare, total one, or unlatch setpoints.
// - Annunciators one and two may show rising and falling trend.
// - Top display shows primary channel in operation and codes when programming.
// - Second and third displays each select an input or processed value.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module fpl_front_panel_lock
    import fpl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        btn_prog_n,
    input  wire logic        btn_up_n,
    input  wire logic        btn_down_n,
    input  wire logic        prog_lockout_on,
    input  wire logic        setp_lockout_on,
    input  wire logic        lock_pin_n,
    input  wire logic        cal_active,
    output logic             lock_notice_short,
    output logic             lock_notice_long,
    output logic             error_notice,
    output logic             annunciator_one,
    output logic             annunciator_two,
    output logic             top_shows_code,
    output logic [3:0]       disp2_source,
    output logic [3:0]       disp3_source,
    output logic [2:0]       view_item,
    output logic [2:0]       mode_out,
    output logic [3:0]       step_out,
    output logic             commit_pulse,
    output logic [6:0]       action_pulse
);

    // ****************************************************************
    // Input debouncing
    // ****************************************************************
    // Active-low contacts count as pressed only when held stable; open reads as released.
    logic [4:0] raw_s;
    logic [4:0] stab_q;
    logic [4:0] prev_q;
    logic [FPL_DB_W-1:0] db_cnt_q [5];

    assign raw_s = {~lock_pin_n, setp_lockout_on, prog_lockout_on, ~btn_down_n, ~btn_up_n};
    logic prog_raw;
    logic prog_stab_q;
    logic prog_prev_q;
    logic [FPL_DB_W-1:0] prog_cnt_q;
    assign prog_raw = ~btn_prog_n;

    function automatic logic [FPL_DB_W-1:0] db_next(input logic [FPL_DB_W-1:0] cnt,
                                                    input logic raw, input logic stab);
        if (raw == stab)
            return '0;
        return cnt + 1'b1;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stab_q <= '0;
            prev_q <= '0;
            prog_stab_q <= 1'b0;
            prog_prev_q <= 1'b0;
            prog_cnt_q <= '0;
            for (int i = 0; i < 5; i++) db_cnt_q[i] <= '0;
        end else begin
            prev_q <= stab_q;
            prog_prev_q <= prog_stab_q;
            for (int i = 0; i < 5; i++) begin
                db_cnt_q[i] <= db_next(db_cnt_q[i], raw_s[i], stab_q[i]);
                if (db_cnt_q[i] == FPL_DB_W'(FPL_DEBOUNCE_CYC - 1)) begin
                    stab_q[i] <= raw_s[i];
                    db_cnt_q[i] <= '0;
                end
            end
            prog_cnt_q <= db_next(prog_cnt_q, prog_raw, prog_stab_q);
            if (prog_cnt_q == FPL_DB_W'(FPL_DEBOUNCE_CYC - 1)) begin
                prog_stab_q <= prog_raw;
                prog_cnt_q <= '0;
            end
        end
    end

    // Press events. A chord fires when the second button of the pair becomes stable
    // while the other is already stable; a lone program press fires on release so that it cannot
    // be mistaken for the start of a chord, while a lone arrow press fires when it becomes stable.
    logic up_s, dn_s, pin_s;
    logic up_rise, dn_rise, prog_rise, prog_fall, pin_rise;
    logic chord_up, chord_dn, chord_used_q;
    logic prog_single, up_single, dn_single;
    assign up_s     = stab_q[0];
    assign dn_s     = stab_q[1];
    assign pin_s    = stab_q[4];
    assign up_rise  = up_s & ~prev_q[0];
    assign dn_rise  = dn_s & ~prev_q[1];
    assign pin_rise = pin_s & ~prev_q[4];
    assign prog_rise = prog_stab_q & ~prog_prev_q;
    assign prog_fall = ~prog_stab_q & prog_prev_q;
    assign chord_up = prog_stab_q & up_s & (prog_rise | up_rise);
    assign chord_dn = prog_stab_q & dn_s & (prog_rise | dn_rise);
    assign prog_single = prog_fall & ~chord_used_q;
    assign up_single = up_rise & ~prog_stab_q;
    assign dn_single = dn_rise & ~prog_stab_q;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            chord_used_q <= 1'b0;
        else if (chord_up | chord_dn)
            chord_used_q <= 1'b1;
        else if (!prog_stab_q)
            chord_used_q <= 1'b0;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic signed [31:0] cal_lo_q, cal_hi_q, scaled_q;
    logic [15:0] value_q [FPL_STEP_LAST+1];
    logic [6:0]  actions_q;
    logic       aw_have_q, w_have_q, wr_fire, wr_full_q;
    logic [7:0] wr_addr_q;
    logic [31:0] wr_data_q;
    logic [2:0]  pin_fn;
    logic        pin_locked;
    assign pin_fn = ctrl_q[FPL_CTRL_PINFN_LSB +: 3];
    assign pin_locked = pin_s & (pin_fn == FPL_PINFN_LOCK);

    // ****************************************************************
    // Mode sequencing
    // ****************************************************************
    // Step 0 of main mode is brightness; setpoint steps are treated as setpoint values.
    fpl_mode_t mode_q, ret_q;
    logic [3:0] step_q;
    logic [2:0] view_q;
    logic       edit_ok;
    logic       in_prog;
    assign in_prog = (mode_q == FPL_MAIN) | (mode_q == FPL_SETP);
    always_comb begin
        edit_ok = ~stab_q[2];
        if (mode_q == FPL_SETP && stab_q[3])
            edit_ok = 1'b0;
        if (pin_locked && !(mode_q == FPL_MAIN && step_q == 4'h0))
            edit_ok = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= FPL_OPER;
            ret_q <= FPL_OPER;
            step_q <= '0;
            view_q <= '0;
            commit_pulse <= 1'b0;
        end else begin
            commit_pulse <= 1'b0;
            case (mode_q)
                FPL_OPER, FPL_VIEW_UP, FPL_VIEW_DN: begin
                    if (chord_up) begin
                        mode_q <= FPL_MAIN;
                        step_q <= '0;
                        if (prog_lockout_on) mode_q <= FPL_LOCKMSG;
                    end else if (chord_dn) begin
                        mode_q <= FPL_SETP;
                        step_q <= '0;
                        if (prog_lockout_on || pin_locked) mode_q <= FPL_LOCKMSG;
                    end else if (up_single) begin
                        if (mode_q != FPL_VIEW_UP) begin
                            mode_q <= FPL_VIEW_UP;
                            view_q <= '0;
                        end else
                            view_q <= (view_q == 3'(FPL_VIEW_ITEMS - 1)) ? 3'h0 : view_q + 3'h1;
                    end else if (dn_single) begin
                        if (mode_q != FPL_VIEW_DN) begin
                            mode_q <= FPL_VIEW_DN;
                            view_q <= '0;
                        end else
                            view_q <= (view_q == 3'(FPL_VIEW_ITEMS - 1)) ? 3'h0 : view_q + 3'h1;
                    end else if (prog_single)
                        mode_q <= FPL_OPER;
                end
                FPL_MAIN, FPL_SETP: begin
                    if (prog_single) begin
                        commit_pulse <= 1'b1;
                        ret_q <= mode_q;
                        mode_q <= FPL_EXIT_ARM;
                        if (pin_locked && mode_q == FPL_MAIN) mode_q <= FPL_LOCKMSG;
                    end
                end
                FPL_EXIT_ARM: begin
                    if (chord_up || chord_dn)
                        mode_q <= FPL_OPER;
                    else if (up_single || dn_single || prog_single) begin
                        // Any other action resumes at the next step.
                        mode_q <= ret_q;
                        step_q <= (step_q == 4'(FPL_STEP_LAST)) ? 4'h0 : step_q + 4'h1;
                    end
                end
                FPL_LOCKMSG: begin
                    if (chord_up || chord_dn || prog_single)
                        mode_q <= FPL_OPER;
                end
                default: mode_q <= FPL_OPER;
            endcase
        end
    end

    // Value store: only arrow presses change a value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i <= FPL_STEP_LAST; i++) value_q[i] <= FPL_VALUE_RESET;
        end else if (in_prog && edit_ok) begin
            if (up_single)
                value_q[step_q] <= value_q[step_q] + 16'h0001;
            else if (dn_single)
                value_q[step_q] <= value_q[step_q] - 16'h0001;
        end
    end

    // ****************************************************************
    // Error detection and pin actions
    // ****************************************************************
    logic cal_err, scale_err;
    assign cal_err = cal_active & (cal_hi_q < cal_lo_q + FPL_CAL_MIN_SPAN);
    assign scale_err = (scaled_q < FPL_DISP_MIN) | (scaled_q > FPL_DISP_MAX) |
                       ctrl_q[FPL_CTRL_INVALID];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action_pulse <= '0;
            actions_q <= '0;
        end else begin
            action_pulse <= '0;
            if (pin_rise && pin_fn != FPL_PINFN_LOCK)
                action_pulse[pin_fn - 3'h1] <= 1'b1;
            // Sticky log; a new event wins over a clear in the same cycle.
            for (int i = 0; i < 7; i++) begin
                if (pin_rise && pin_fn != FPL_PINFN_LOCK && pin_fn - 3'h1 == 3'(i))
                    actions_q[i] <= 1'b1;
                else if (wr_fire && wr_addr_q == FPL_ADDR_ACTIONS && wr_data_q[i])
                    actions_q[i] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_notice_short <= 1'b0;
            lock_notice_long <= 1'b0;
            error_notice <= 1'b0;
            annunciator_one <= 1'b0;
            annunciator_two <= 1'b0;
            top_shows_code <= 1'b0;
            disp2_source <= '0;
            disp3_source <= '0;
            view_item <= '0;
            mode_out <= '0;
            step_out <= '0;
        end else begin
            lock_notice_short <= (mode_q == FPL_LOCKMSG) & prog_lockout_on;
            lock_notice_long <= (mode_q == FPL_LOCKMSG) & ~prog_lockout_on;
            error_notice <= cal_err | scale_err;
            annunciator_one <= ctrl_q[FPL_CTRL_TREND1] & (scaled_q > cal_lo_q);
            annunciator_two <= ctrl_q[FPL_CTRL_TREND2] & (scaled_q < cal_lo_q);
            top_shows_code <= in_prog | (mode_q == FPL_EXIT_ARM);
            disp2_source <= ctrl_q[FPL_CTRL_DISP2_LSB +: 4];
            disp3_source <= ctrl_q[FPL_CTRL_DISP3_LSB +: 4];
            view_item <= view_q;
            mode_out <= mode_q;
            step_out <= step_q;
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // One write and one read at a time; address and data are captured separately.
    assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            wr_full_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_data_q <= s_axi_wdata;
                wr_full_q <= (s_axi_wstrb == 4'hF);
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr_q == FPL_ADDR_CTRL || wr_addr_q == FPL_ADDR_CAL_LO ||
                                wr_addr_q == FPL_ADDR_CAL_HI || wr_addr_q == FPL_ADDR_SCALED ||
                                wr_addr_q == FPL_ADDR_ACTIONS) ? 2'h0 : 2'h2;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Writes with all byte lanes only; partial strobes are ignored here, though an action-log clear obeys any strobe.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= FPL_CTRL_RESET;
            cal_lo_q <= '0;
            cal_hi_q <= '0;
            scaled_q <= '0;
        end else if (wr_fire && wr_full_q) begin
            case (wr_addr_q)
                FPL_ADDR_CTRL:   ctrl_q <= wr_data_q & FPL_CTRL_MASK;
                FPL_ADDR_CAL_LO: cal_lo_q <= wr_data_q;
                FPL_ADDR_CAL_HI: cal_hi_q <= wr_data_q;
                FPL_ADDR_SCALED: scaled_q <= wr_data_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr[7:0])
                    FPL_ADDR_CTRL:    s_axi_rdata <= ctrl_q;
                    FPL_ADDR_STATUS:  s_axi_rdata <= {18'h0, view_q, step_q, mode_q,
                                                      pin_locked, scale_err, cal_err, edit_ok};
                    FPL_ADDR_VALUE:   s_axi_rdata <= {16'h0, value_q[step_q]};
                    FPL_ADDR_CAL_LO:  s_axi_rdata <= cal_lo_q;
                    FPL_ADDR_CAL_HI:  s_axi_rdata <= cal_hi_q;
                    FPL_ADDR_SCALED:  s_axi_rdata <= scaled_q;
                    FPL_ADDR_ACTIONS: s_axi_rdata <= {25'h0, actions_q};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // fpl_front_panel_lock

//--- verification/fpl_checker.sv
// Port-level checks for the front-panel lock control block.
`timescale 1ns/100ps
module fpl_checker
    import fpl_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       btn_prog_n,
    input wire logic       btn_up_n,
    input wire logic       btn_down_n,
    input wire logic       prog_lockout_on,
    input wire logic       lock_pin_n,
    input wire logic       lock_notice_short,
    input wire logic       lock_notice_long,
    input wire logic       top_shows_code,
    input wire logic       commit_pulse,
    input wire logic [2:0] view_item,
    input wire logic [2:0] mode_out,
    input wire logic [6:0] action_pulse
);
    // Cycles since any button moved; a bounce must never reach the mode logic.
    logic [2:0]  btn_q;
    logic [11:0] calm_q;
    always_ff @(posedge aclk) begin
        btn_q <= {btn_prog_n, btn_up_n, btn_down_n};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || btn_q != {btn_prog_n, btn_up_n, btn_down_n})
            calm_q <= 12'h000;
        else if (calm_q != 12'hFFF)
            calm_q <= calm_q + 12'h001;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_commit_once: assert property (commit_pulse |=> !commit_pulse)
        else $error("commit pulse lasted more than one cycle");
    chk_commit_arms: assert property (commit_pulse |=> mode_out inside {FPL_EXIT_ARM, FPL_LOCKMSG})
        else $error("commit without arming the exit");
    chk_chord_calm: assert property (($past(mode_out) == FPL_OPER &&
        mode_out inside {FPL_MAIN, FPL_SETP}) |-> calm_q >= 12'd1992)
        else $error("programming entered before buttons settled");
    chk_oper_top: assert property ((mode_out == FPL_OPER &&
        $past(mode_out) == FPL_OPER) |-> !top_shows_code)
        else $error("top display shows codes in operation");
    chk_lock_short: assert property ($rose(lock_notice_short) |-> prog_lockout_on)
        else $error("short lock notice without lockout switch");
    chk_lock_long: assert property ($rose(lock_notice_long) |-> !lock_pin_n)
        else $error("long lock notice without lock pin");
    chk_action_hot: assert property (action_pulse != 7'h00 |->
        $onehot(action_pulse) ##1 action_pulse == 7'h00)
        else $error("pin action not a single one-cycle pulse");
    chk_view_range: assert property (view_item <= 3'h6)
        else $error("view index beyond last item");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    cov_main: cover property (mode_out == FPL_MAIN);
    cov_pin_lock: cover property (lock_notice_long);
    cov_unlatch: cover property (action_pulse == 7'h40);
endmodule // fpl_checker

bind fpl_front_panel_lock fpl_checker u_chk (.*);

//--- verification/fpl_operator.sv
// Operator model: front buttons and the rear lock pin.
`timescale 1ns/100ps
module fpl_operator (
    input  wire logic aclk,
    output logic      btn_prog_n,
    output logic      btn_up_n,
    output logic      btn_down_n,
    output logic      lock_pin_n
);
    // Open contacts read high; a closure to common reads low.
    initial {btn_prog_n, btn_up_n, btn_down_n, lock_pin_n} = 4'hF;
    // Holds a pattern {prog, up, down, pin} past the settling time.
    task automatic hold(input logic [3:0] k);
        @(posedge aclk);
        {btn_prog_n, btn_up_n, btn_down_n, lock_pin_n} <= ~k;
        repeat (2040) @(posedge aclk);
    endtask
endmodule // fpl_operator

//--- verification/tb.sv
// Self-checking bench for the front-panel lock control block.
`timescale 1ns/100ps
module tb;
    import fpl_pkg::*;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", n, e, s); end end
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cal_active;
    logic btn_prog_n, btn_up_n, btn_down_n, prog_lockout_on, setp_lockout_on, lock_pin_n;
    logic lock_notice_short, lock_notice_long, error_notice, annunciator_one, annunciator_two;
    logic        top_shows_code, commit_pulse;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_q, d;
    logic [3:0]  s_axi_wstrb, disp2_source, disp3_source, step_out, pin;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q;
    logic [2:0]  view_item, mode_out;
    logic [6:0]  action_pulse, acts;
    int          failures, tests_run, cyc, commits, stp, fn, vals[16];
    fpl_front_panel_lock dut (.*);
    fpl_operator op (.*);
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        commits += (commit_pulse === 1'b1);
        acts <= acts | action_pulse;
        if (cyc == 96000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        rresp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Pattern bits are {prog, up, down, pin}; the pin stays as set by the scenario.
    task automatic press(input logic [3:0] k);
        op.hold(k | pin);
        op.hold(pin);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {cal_active, prog_lockout_on, setp_lockout_on, pin, acts, stp} = 0;
        vals = '{default: 0};
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
        s_axi_wstrb = 4'hF;
        void'($urandom(34609));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FPL_ADDR_CTRL);
        `CHK("ctrl reset", FPL_CTRL_RESET, rd_q)
        `CHK("mode reset", 3'(FPL_OPER), mode_out)
        d = $urandom | 32'h0001_0000;
        wr(FPL_ADDR_CTRL, d);
        rd(FPL_ADDR_CTRL);
        `CHK("ctrl", d & FPL_CTRL_MASK, rd_q)
        `CHK("disp2", d[11:8], disp2_source)
        `CHK("disp3", d[15:12], disp3_source)
        `CHK("error", 1'b1, error_notice)
        rd(8'h1C);
        `CHK("unmapped", 2'h2, rresp_q)
        wr(FPL_ADDR_CTRL, 32'h0);
        rd(FPL_ADDR_STATUS);
        `CHK("no error", 1'b0, error_notice)
        press(4'hC);
        `CHK("main", 3'(FPL_MAIN), mode_out)
        `CHK("code top", 1'b1, top_shows_code)
        press(4'h4);
        press(4'h4);
        press(4'h2);
        vals[stp] += 1;
        rd(FPL_ADDR_VALUE);
        `CHK("edit", 32'(vals[stp]), rd_q)
        press(4'h8);
        `CHK("commit", 1, commits)
        `CHK("armed", 3'(FPL_EXIT_ARM), mode_out)
        press(4'h4);
        stp++;
        `CHK("step", 4'(stp), step_out)
        rd(FPL_ADDR_VALUE);
        `CHK("passed", 32'(vals[stp]), rd_q)
        press(4'h8);
        press(4'hC);
        `CHK("exit", 3'(FPL_OPER), mode_out)
        prog_lockout_on <= 1'b1;
        op.hold(4'h0);
        press(4'hC);
        `CHK("lockout", 3'(FPL_LOCKMSG), mode_out)
        `CHK("short", 1'b1, lock_notice_short)
        press(4'h8);
        prog_lockout_on <= 1'b0;
        pin = 4'h1;
        press(4'hA);
        `CHK("pin lock", 3'(FPL_LOCKMSG), mode_out)
        `CHK("long", 1'b1, lock_notice_long)
        press(4'h8);
        pin = 4'h0;
        op.hold(4'h0);
        `CHK("unlock", 3'(FPL_OPER), mode_out)
        for (fn = 1; fn < 8; fn++) begin
            wr(FPL_ADDR_CTRL, 32'(fn));
            op.hold(4'h1);
            op.hold(4'h0);
            `CHK("action", 7'((1 << fn) - 1), acts)
        end
        rd(FPL_ADDR_ACTIONS);
        `CHK("action log", 32'h7F, rd_q)
        press(4'h4);
        `CHK("view", 3'(FPL_VIEW_UP), mode_out)
        press(4'h4);
        `CHK("view next", 3'h1, view_item)
        cal_active <= 1'b1;
        rd(FPL_ADDR_STATUS);
        `CHK("cal span", 1'b1, error_notice)
        final_report();
    end
endmodule // tb
